//--- pcr_config_registers.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_config_registers
  import pcr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PCR_TICK_CYCLES,
  parameter int unsigned HOLD_SHORT  = `PCR_HOLD_SHORT_MS,
  parameter int unsigned HOLD_LONG   = `PCR_HOLD_LONG_MS
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  input  wire logic       voltage_commit,
  input  wire logic       voltage_commit_no_discharge,
  input  wire logic       output_one_level,
  input  wire logic       output_two_level,
  input  wire logic       output_three_level,
  input  wire logic [2:0] switch_enable,
  input  wire logic       push_button_n,
  input  wire logic       rails_in_range,
  input  wire logic       power_fail_out_low,
  input  wire logic       general_pin_one_in,
  output logic            general_pin_one_out,
  output logic            general_pin_one_oe_n,
  output logic            general_output_two_out,
  output logic            general_output_two_oe_n,
  output logic            general_output_two_from_switch_one_supply,
  input  wire logic       general_pin_three_in,
  output logic            general_pin_three_out,
  output logic            general_pin_three_oe_n,
  output logic            buck_warm_reset,
  output logic            push_button_reset,
  output logic            power_good,
  output logic            tight_limits,
  output logic            overvoltage_monitor_en,
  output logic            undervoltage_monitor_en,
  output logic [1:0]      undervoltage_lockout_level,
  output logic            lockout_hysteresis_select,
  output logic [1:0]      switch_three_limit,
  output logic [1:0]      switch_two_limit,
  output logic [2:0]      switch_on,
  output logic [2:0]      switch_discharge,
  output logic [5:0]      buck_one_code,
  output logic            pulse_skip_enable
);

  pcr_state_t s;
  pcr_state_t next_s;

  function automatic logic [7:0] pcr_pg_delay(input logic [1:0] sel);
    unique case (sel)
      2'h0: pcr_pg_delay = `PCR_PG_DELAY0_MS;
      2'h1: pcr_pg_delay = `PCR_PG_DELAY1_MS;
      2'h2: pcr_pg_delay = `PCR_PG_DELAY2_MS;
      2'h3: pcr_pg_delay = `PCR_PG_DELAY3_MS;
    endcase
  endfunction

  function automatic logic pcr_protected(input logic [7:0] addr);
    pcr_protected = (addr == `PCR_ADDR_GENERAL) || (addr == `PCR_ADDR_RESET_PIN) ||
                    (addr == `PCR_ADDR_SWITCH_PROT) || (addr == `PCR_ADDR_BUCK_ONE);
  endfunction

  logic        wr_ok;
  logic [13:0] hold_target;
  logic        pin_one_route;
  logic        warm_reset_en;
  logic        pin_one_level;
  logic        out_two_level;
  logic [2:0]  fail_off;

  assign pin_one_route = s.general_config[`PCR_GEN_PIN1_ROUTE];
  assign warm_reset_en = s.reset_pin_and_limit_config[`PCR_RP_WARM_RESET];
  assign fail_off = s.switch_protection_config[`PCR_SP_FAIL_OFF_HI:`PCR_SP_FAIL_OFF_LO];
  assign wr_ok = reg_write && s.unlocked && pcr_protected(reg_addr);
  assign hold_target = s.general_config[`PCR_GEN_HOLD_LONG] ?
                       14'(HOLD_LONG) : 14'(HOLD_SHORT);

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.tick_div == 20'(TICK_CYCLES - 1)) begin
      next_s.tick_div = 20'h00000;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_div = s.tick_div + 20'h00001;
    end

    next_s.button_sync = {s.button_sync[0], push_button_n};
    next_s.rails_sync = {s.rails_sync[0], rails_in_range};
    next_s.fail_sync = {s.fail_sync[0], power_fail_out_low};
    next_s.pin_one_sync = {s.pin_one_sync[0], general_pin_one_in};
    next_s.pin_three_sync = {s.pin_three_sync[0], general_pin_three_in};

    // unlock lasts for the next write only
    if (reg_write) begin
      next_s.unlocked = (reg_addr == `PCR_ADDR_PASSWORD) &&
                        (reg_wdata == `PCR_UNLOCK_KEY);
    end

    if (wr_ok) begin
      unique case (reg_addr)
        `PCR_ADDR_GENERAL:
          next_s.general_config = reg_wdata & `PCR_MASK_GENERAL;
        `PCR_ADDR_RESET_PIN:
          next_s.reset_pin_and_limit_config = reg_wdata & `PCR_MASK_RESET_PIN;
        `PCR_ADDR_SWITCH_PROT:
          next_s.switch_protection_config = reg_wdata & `PCR_MASK_SWITCH_PROT;
        `PCR_ADDR_BUCK_ONE: begin
          next_s.buck_one_voltage = reg_wdata & `PCR_MASK_BUCK_ONE;
          next_s.blanking = 1'b1;
          next_s.blank_ms = 3'h0;
        end
        default: ;
      endcase
    end

    if (reg_read) begin
      unique case (reg_addr)
        `PCR_ADDR_GENERAL:     next_s.reg_rdata = s.general_config;
        `PCR_ADDR_RESET_PIN:   next_s.reg_rdata = s.reset_pin_and_limit_config;
        `PCR_ADDR_SWITCH_PROT: next_s.reg_rdata = s.switch_protection_config;
        `PCR_ADDR_BUCK_ONE:    next_s.reg_rdata = s.buck_one_voltage;
        default:               next_s.reg_rdata = 8'h00;
      endcase
    end

    if (voltage_commit || voltage_commit_no_discharge) begin
      next_s.buck_one_code_applied =
        s.buck_one_voltage[`PCR_BK_CODE_HI:`PCR_BK_CODE_LO];
    end

    // blanking restarts on a write in the same cycle as its expiry
    if (s.blanking && s.tick && !(wr_ok && reg_addr == `PCR_ADDR_BUCK_ONE)) begin
      if (s.blank_ms == `PCR_BLANK_MS - 3'h1) begin
        next_s.blanking = 1'b0;
      end else begin
        next_s.blank_ms = s.blank_ms + 3'h1;
      end
    end

    if (s.button_sync[1]) begin
      next_s.hold_ms = 14'h0000;
      next_s.push_button_reset = 1'b0;
    end else if (s.hold_ms >= hold_target) begin
      next_s.push_button_reset = 1'b1;
    end else if (s.tick) begin
      next_s.hold_ms = s.hold_ms + 14'h0001;
    end

    if (!s.rails_sync[1]) begin
      next_s.power_good = 1'b0;
      next_s.pg_ms = 8'h00;
    end else if (!s.power_good) begin
      if (s.pg_ms >= pcr_pg_delay(
            s.general_config[`PCR_GEN_PG_DELAY_HI:`PCR_GEN_PG_DELAY_LO])) begin
        next_s.power_good = 1'b1;
      end else if (s.tick) begin
        next_s.pg_ms = s.pg_ms + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.general_config <= `PCR_RST_GENERAL;
      s.reset_pin_and_limit_config <= `PCR_RST_RESET_PIN;
      s.switch_protection_config <= `PCR_RST_SWITCH_PROT;
      s.buck_one_voltage <= `PCR_RST_BUCK_ONE;
      s.buck_one_code_applied <= 6'(`PCR_RST_BUCK_ONE);
      // pins start at their inactive level
      s.button_sync <= 2'h3;
      s.fail_sync <= 2'h3;
      s.pin_three_sync <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.reg_rdata;

  // pin one: open-drain output, or input steering output two
  assign general_pin_one_out = 1'b0;
  assign general_pin_one_oe_n = pin_one_route | output_one_level;
  assign pin_one_level = s.pin_one_sync[1];
  assign out_two_level = pin_one_route ? pin_one_level : output_two_level;

  // output two: push-pull high level comes from switch one supply
  always_comb begin
    if (s.general_config[`PCR_GEN_OUT2_PUSHPULL]) begin
      general_output_two_out = out_two_level;
      general_output_two_oe_n = 1'b0;
    end else begin
      general_output_two_out = 1'b0;
      general_output_two_oe_n = out_two_level;
    end
  end
  assign general_output_two_from_switch_one_supply =
    s.general_config[`PCR_GEN_OUT2_PUSHPULL];

  // pin three: open-drain output or warm-reset input
  assign general_pin_three_out = 1'b0;
  assign general_pin_three_oe_n = warm_reset_en | output_three_level;
  assign buck_warm_reset = warm_reset_en & ~s.pin_three_sync[1];

  assign push_button_reset = s.push_button_reset;
  assign power_good = s.power_good;

  assign tight_limits = s.general_config[`PCR_GEN_TIGHT];
  assign overvoltage_monitor_en = s.general_config[`PCR_GEN_TIGHT] & ~s.blanking;
  assign undervoltage_monitor_en = ~s.blanking;
  assign undervoltage_lockout_level =
    s.general_config[`PCR_GEN_LOCKOUT_HI:`PCR_GEN_LOCKOUT_LO];
  assign lockout_hysteresis_select = s.reset_pin_and_limit_config[`PCR_RP_HYST];
  assign switch_three_limit =
    s.reset_pin_and_limit_config[`PCR_RP_LIM3_HI:`PCR_RP_LIM3_LO];
  assign switch_two_limit =
    s.reset_pin_and_limit_config[`PCR_RP_LIM2_HI:`PCR_RP_LIM2_LO];

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_switch
      assign switch_on[i] = switch_enable[i] & ~(fail_off[i] & ~s.fail_sync[1]);
      assign switch_discharge[i] =
        s.switch_protection_config[`PCR_SP_DISCH_LO + i] & ~switch_on[i];
    end
  endgenerate

  assign buck_one_code = s.buck_one_code_applied;
  assign pulse_skip_enable = s.buck_one_voltage[`PCR_BK_PULSE_SKIP];

endmodule

//--- pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// subaddresses
`define PCR_ADDR_PASSWORD      8'h10
`define PCR_ADDR_GENERAL       8'h13
`define PCR_ADDR_RESET_PIN     8'h14
`define PCR_ADDR_SWITCH_PROT   8'h15
`define PCR_ADDR_BUCK_ONE      8'h16

// reset values
`define PCR_RST_GENERAL        8'h08
`define PCR_RST_RESET_PIN      8'hc0
`define PCR_RST_SWITCH_PROT    8'h00
`define PCR_RST_BUCK_ONE       8'hab

// writable bits, reserved bits read as zero
`define PCR_MASK_GENERAL       8'hff
`define PCR_MASK_RESET_PIN     8'hcf
`define PCR_MASK_SWITCH_PROT   8'h3f
`define PCR_MASK_BUCK_ONE      8'hbf

// unlock key, value arbitrary
`define PCR_UNLOCK_KEY         8'h7d

// general_config fields
`define PCR_GEN_HOLD_LONG      7
`define PCR_GEN_OUT2_PUSHPULL  6
`define PCR_GEN_PIN1_ROUTE     5
`define PCR_GEN_PG_DELAY_HI    4
`define PCR_GEN_PG_DELAY_LO    3
`define PCR_GEN_TIGHT          2
`define PCR_GEN_LOCKOUT_HI     1
`define PCR_GEN_LOCKOUT_LO     0

// reset_pin_and_limit_config fields
`define PCR_RP_WARM_RESET      7
`define PCR_RP_HYST            6
`define PCR_RP_LIM3_HI         3
`define PCR_RP_LIM3_LO         2
`define PCR_RP_LIM2_HI         1
`define PCR_RP_LIM2_LO         0

// switch_protection_config fields
`define PCR_SP_FAIL_OFF_HI     5
`define PCR_SP_FAIL_OFF_LO     3
`define PCR_SP_DISCH_HI        2
`define PCR_SP_DISCH_LO        0

// buck_one_voltage fields
`define PCR_BK_PULSE_SKIP      7
`define PCR_BK_CODE_HI         5
`define PCR_BK_CODE_LO         0

// timing
`define PCR_CLK_PERIOD_NS      10
`define PCR_TICK_MS            1
`define PCR_TICK_CYCLES        ((`PCR_TICK_MS * 1000000) / `PCR_CLK_PERIOD_NS)
`define PCR_HOLD_SHORT_S       8
`define PCR_HOLD_LONG_S        15
`define PCR_HOLD_SHORT_MS      (`PCR_HOLD_SHORT_S * 1000)
`define PCR_HOLD_LONG_MS       (`PCR_HOLD_LONG_S * 1000)
`define PCR_PG_DELAY0_MS       8'd10
`define PCR_PG_DELAY1_MS       8'd20
`define PCR_PG_DELAY2_MS       8'd50
`define PCR_PG_DELAY3_MS       8'd150
`define PCR_BLANK_MS           3'd5

`endif

//--- pcr_pkg.sv
package pcr_pkg;

  typedef struct packed {
    logic [7:0]  general_config;
    logic [7:0]  reset_pin_and_limit_config;
    logic [7:0]  switch_protection_config;
    logic [7:0]  buck_one_voltage;
    logic [5:0]  buck_one_code_applied;
    logic        unlocked;
    logic [7:0]  reg_rdata;
    logic [19:0] tick_div;
    logic        tick;
    logic [1:0]  button_sync;
    logic [1:0]  rails_sync;
    logic [1:0]  fail_sync;
    logic [1:0]  pin_one_sync;
    logic [1:0]  pin_three_sync;
    logic [13:0] hold_ms;
    logic        push_button_reset;
    logic [7:0]  pg_ms;
    logic        power_good;
    logic [2:0]  blank_ms;
    logic        blanking;
  } pcr_state_t;

endpackage

//--- pcr_config_registers_assertions.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_config_registers_assertions (
  input logic       clk,
  input logic       rst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_write,
  input logic       reg_read,
  input logic [7:0] reg_rdata,
  input logic       voltage_commit,
  input logic       voltage_commit_no_discharge,
  input logic [2:0] switch_enable,
  input logic       rails_in_range,
  input logic       power_good,
  input logic       tight_limits,
  input logic       overvoltage_monitor_en,
  input logic       undervoltage_monitor_en,
  input logic [2:0] switch_on,
  input logic [2:0] switch_discharge,
  input logic [5:0] buck_one_code,
  input logic       pulse_skip_enable,
  input logic       push_button_reset
);
  logic unl;
  // tracks whether the previous write was the unlock key
  always_ff @(posedge clk or posedge rst) begin
    if (rst) unl <= 1'b0;
    else if (reg_write) unl <= (reg_addr == 8'h10) && (reg_wdata == `PCR_UNLOCK_KEY);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_res_read_zero: assert property (
    reg_read && reg_addr == `PCR_ADDR_SWITCH_PROT |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits set");
  a_buck_res_zero: assert property (
    reg_read && reg_addr == `PCR_ADDR_BUCK_ONE |=> !reg_rdata[6]) else $error("buck bit 6 set");
  a_discharge_off: assert property (
    (switch_on & switch_discharge) == 3'b000) else $error("discharge on live switch");
  a_switch_gated: assert property (
    (switch_on & ~switch_enable) == 3'b000) else $error("switch on while disabled");
  a_pg_fall_fast: assert property (
    $fell(rails_in_range) |-> ##[0:3] !power_good) else $error("power good fell late");
  a_pg_rise_late: assert property (
    $rose(rails_in_range) && !power_good |=> !power_good [*8]) else $error("power good early");
  a_blank_start: assert property (
    reg_write && unl && reg_addr == `PCR_ADDR_BUCK_ONE |=> !undervoltage_monitor_en [*8])
    else $error("monitoring not blanked");
  a_locked_drop: assert property (
    reg_write && !unl && reg_addr == `PCR_ADDR_BUCK_ONE |=> $stable(pulse_skip_enable))
    else $error("locked write took effect");
  a_code_held: assert property (
    !voltage_commit && !voltage_commit_no_discharge |=> $stable(buck_one_code))
    else $error("voltage code changed without commit");
  a_ov_tight: assert property (
    overvoltage_monitor_en |-> tight_limits) else $error("overvoltage without tight limits");
  c_unlocked_write: cover property (reg_write && unl);
  c_pg_fall: cover property ($fell(power_good));
  c_button: cover property ($rose(push_button_reset));
endmodule
bind pcr_config_registers pcr_config_registers_assertions chk (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .voltage_commit,
  .voltage_commit_no_discharge, .switch_enable, .rails_in_range, .power_good, .tight_limits,
  .overvoltage_monitor_en, .undervoltage_monitor_en, .switch_on, .switch_discharge,
  .buck_one_code, .pulse_skip_enable, .push_button_reset
);

//--- pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model (
  input  logic       clk,
  input  logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_write,
  output logic       reg_read
);
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
  end
  // bus left scrambled after each access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_write, reg_read, voltage_commit, voltage_commit_no_discharge;
  logic       output_one_level, output_two_level, output_three_level, push_button_n;
  logic       rails_in_range, power_fail_out_low, general_pin_one_in, general_pin_three_in;
  logic       general_pin_one_out, general_pin_one_oe_n, general_output_two_out;
  logic       general_output_two_oe_n, general_output_two_from_switch_one_supply;
  logic       general_pin_three_out, general_pin_three_oe_n, buck_warm_reset;
  logic       push_button_reset, power_good, tight_limits, overvoltage_monitor_en;
  logic       undervoltage_monitor_en, lockout_hysteresis_select, pulse_skip_enable;
  logic [1:0] undervoltage_lockout_level, switch_three_limit, switch_two_limit;
  logic [2:0] switch_enable, switch_on, switch_discharge, e;
  logic [5:0] buck_one_code, ap;
  logic [7:0] mdl [4];
  logic [7:0] msk [4] = '{8'hff, 8'hcf, 8'h3f, 8'hbf};
  logic       unl;
  int         bad_count, n_compared;
  int         dly [4] = '{10, 20, 50, 150};
  always #5 clk = ~clk;
  pcr_config_registers #(.TICK_CYCLES(4), .HOLD_SHORT(3), .HOLD_LONG(6)) DUT (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .voltage_commit,
    .voltage_commit_no_discharge, .output_one_level, .output_two_level, .output_three_level,
    .switch_enable, .push_button_n, .rails_in_range, .power_fail_out_low, .general_pin_one_in,
    .general_pin_one_out, .general_pin_one_oe_n, .general_output_two_out,
    .general_output_two_oe_n, .general_output_two_from_switch_one_supply,
    .general_pin_three_in, .general_pin_three_out, .general_pin_three_oe_n, .buck_warm_reset,
    .push_button_reset, .power_good, .tight_limits, .overvoltage_monitor_en,
    .undervoltage_monitor_en, .undervoltage_lockout_level, .lockout_hysteresis_select,
    .switch_three_limit, .switch_two_limit, .switch_on, .switch_discharge, .buck_one_code,
    .pulse_skip_enable
  );
  pcr_host_model h (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h.wr(a, d);
    if (unl && a >= 8'h13 && a <= 8'h16) mdl[a - 8'h13] = d & msk[a - 8'h13];
    unl = (a == 8'h10) && (d == `PCR_UNLOCK_KEY);
  endtask
  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    wr(8'h10, `PCR_UNLOCK_KEY);
    wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a);
    logic [7:0] d;
    h.rd(a, d);
    chk("rdata", (a >= 8'h13 && a <= 8'h16) ? mdl[a - 8'h13] : 8'h00, d);
  endtask
  task automatic fields;
    chk("lockout", 8'(mdl[0][1:0]), 8'(undervoltage_lockout_level));
    chk("tight", 8'(mdl[0][2]), 8'(tight_limits));
    chk("out2_pp", 8'(mdl[0][6]), 8'(general_output_two_from_switch_one_supply));
    chk("hyst", 8'(mdl[1][6]), 8'(lockout_hysteresis_select));
    chk("lim3", 8'(mdl[1][3:2]), 8'(switch_three_limit));
    chk("lim2", 8'(mdl[1][1:0]), 8'(switch_two_limit));
    chk("pulse_skip", 8'(mdl[3][7]), 8'(pulse_skip_enable));
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    bad_count++;
    print_verdict;
  end
  initial begin
    {voltage_commit, voltage_commit_no_discharge, general_pin_one_in} <= '0;
    {general_pin_three_in, rails_in_range, switch_enable} <= '0;
    {output_one_level, output_two_level, output_three_level} <= '1;
    {push_button_n, power_fail_out_low} <= '1;
    mdl = '{8'h08, 8'hc0, 8'h00, 8'hab};
    unl = 1'b0;
    ap = 6'h2b;
    void'($urandom(60));
    cyc(10);
    rst <= 1'b0;
    cyc(4);
    for (int i = 0; i < 4; i++) rdc(8'(8'h13 + i));
    fields;
    chk("warm_reset", 8'h01, 8'(buck_warm_reset));
    chk("pin3_oe_n", 8'h01, 8'(general_pin_three_oe_n));
    wr(8'h13, 8'hff);
    rdc(8'h13);
    wr(8'h10, `PCR_UNLOCK_KEY);
    wr(8'h20, 8'h00);
    wr(8'h14, 8'h00);
    rdc(8'h14);
    wr(8'h16, 8'h00);
    rdc(8'h16);
    rdc(8'h10);
    rdc(8'h20);
    repeat (3) for (int i = 0; i < 4; i++) begin
      pw(8'(8'h13 + i), 8'($urandom));
      rdc(8'(8'h13 + i));
      fields;
    end
    pw(8'h13, 8'h04);
    for (int k = 0; k < 2; k++) begin
      pw(8'h16, 8'($urandom));
      cyc(1);
      chk("blank", 8'h00, 8'(undervoltage_monitor_en));
      chk("ov_blank", 8'h00, 8'(overvoltage_monitor_en));
      chk("code_hold", 8'(ap), 8'(buck_one_code));
      if (k == 0) voltage_commit <= 1'b1;
      else voltage_commit_no_discharge <= 1'b1;
      cyc(2);
      {voltage_commit, voltage_commit_no_discharge} <= 2'b00;
      ap = mdl[3][5:0];
      chk("code_new", 8'(ap), 8'(buck_one_code));
      cyc(30);
      chk("unblank", 8'h01, 8'(undervoltage_monitor_en));
      chk("ov_on", 8'h01, 8'(overvoltage_monitor_en));
    end
    for (int c = 0; c < 4; c++) begin
      pw(8'h13, 8'(c << 3));
      rails_in_range <= 1'b1;
      cyc(dly[c] * 4 - 6);
      chk("pg_early", 8'h00, 8'(power_good));
      cyc(14);
      chk("pg_late", 8'h01, 8'(power_good));
      rails_in_range <= 1'b0;
      cyc(4);
      chk("pg_fall", 8'h00, 8'(power_good));
    end
    for (int b = 0; b < 2; b++) begin
      pw(8'h13, 8'(8'h08 | (b << 7)));
      push_button_n <= 1'b0;
      cyc((b ? 6 : 3) * 4 - 6);
      chk("pb_early", 8'h00, 8'(push_button_reset));
      cyc(14);
      chk("pb_late", 8'h01, 8'(push_button_reset));
      push_button_n <= 1'b1;
      cyc(4);
    end
    for (int i = 0; i < 4; i++) begin
      pw(8'h15, 8'($urandom));
      switch_enable <= 3'($urandom);
      power_fail_out_low <= 1'($urandom);
      cyc(4);
      e = switch_enable & ~(power_fail_out_low ? 3'b000 : mdl[2][5:3]);
      chk("switch_on", 8'(e), 8'(switch_on));
      chk("discharge", 8'(~e & mdl[2][2:0]), 8'(switch_discharge));
    end
    pw(8'h13, 8'h20);
    for (int v = 0; v < 2; v++) begin
      general_pin_one_in <= 1'(v);
      cyc(4);
      chk("out2_oe_n", 8'(v), 8'(general_output_two_oe_n));
    end
    output_one_level <= 1'b0;
    output_two_level <= 1'b0;
    cyc(2);
    chk("pin1_oe_n", 8'h01, 8'(general_pin_one_oe_n));
    chk("out2_oe_n", 8'h01, 8'(general_output_two_oe_n));
    pw(8'h13, 8'h60);
    cyc(2);
    chk("out2_out", 8'h01, 8'(general_output_two_out));
    chk("out2_pp_oe_n", 8'h00, 8'(general_output_two_oe_n));
    pw(8'h13, 8'h00);
    cyc(2);
    chk("pin1_oe_n", 8'h00, 8'(general_pin_one_oe_n));
    chk("out2_oe_n", 8'h00, 8'(general_output_two_oe_n));
    chk("pin1_out", 8'h00, 8'(general_pin_one_out));
    pw(8'h14, 8'h40);
    output_three_level <= 1'b0;
    cyc(2);
    chk("pin3_oe_n", 8'h00, 8'(general_pin_three_oe_n));
    chk("warm_reset", 8'h00, 8'(buck_warm_reset));
    chk("pin3_out", 8'h00, 8'(general_pin_three_out));
    print_verdict;
  end
endmodule
